//--- logic/ret_exec_defs.svh
// Constants for the return instruction execution block.
`ifndef RET_EXEC_DEFS_SVH
`define RET_EXEC_DEFS_SVH
`define PC_W             13
`define STACK_DEPTH      8
`define SP_W             3
`define INT_EN_BIT       7
`define INTCTL_RST       8'h00
`define STATUS_RST       8'h00
`define W_RST            8'h00
`define PC_RST           13'h0000
`define RET_CYCLES       2
`define OPC_NOP          14'h0000
`define OPC_RETURN       14'h0008
`define OPC_RET_INT      14'h0009
`define OPC_RET_LIT_HI   6'h0d
`define OPC_CALL_HI      3'h4
`endif

//--- logic/ret_exec_pkg.sv
// Types for the return instruction execution block.
package ret_exec_pkg;
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_FLUSH = 2'b01
  } exec_state_t;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_RETURN = 3'b001,
    OP_RET_INT = 3'b010,
    OP_RET_LIT = 3'b011,
    OP_CALL   = 3'b100
  } ret_op_t;

  typedef struct packed {
    logic        valid;
    logic [13:0] word;
  } instr_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  w;
    logic [7:0]  intctl;
  } core_regs_t;
endpackage

//--- logic/return_instruction_execution.sv
// Executes the subroutine and interrupt return instructions of the core.
//
// Function
// - Interrupt return pops stack into PC; one word, two cycles.
// - Interrupt return sets interrupt enable bit 7; flags unchanged.
// - Literal return writes its eight-bit literal into W; flags kept.
// - Literal return pops stack into PC; two cycles total.
// - Plain return pops stack into PC over two cycles; nothing else.
`timescale 1ns/1ns
`include "ret_exec_defs.svh"

module return_instruction_execution
  import ret_exec_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire instr_t            instr,
  output logic                   instr_taken,
  output logic [`PC_W-1:0]       pc,
  output core_regs_t             regs,
  output logic                   global_interrupt_enable,
  output logic [`PC_W-1:0]       stack_top_entry,
  output logic                   busy
);

  ////////////////////////////////////////////////////////////////////////
  // Decode.

  ret_op_t                op;
  logic    [7:0]          literal;

  always_comb
  begin
    literal = instr.word[7:0];
    op      = OP_NONE;
    if (instr.valid)
    begin
      if (instr.word == `OPC_RETURN)
        op = OP_RETURN;
      else if (instr.word == `OPC_RET_INT)
        op = OP_RET_INT;
      else if (instr.word[13:8] == `OPC_RET_LIT_HI)
        op = OP_RET_LIT;
      else if (instr.word[13:11] == `OPC_CALL_HI)
        op = OP_CALL;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Execution state, program counter, stack and registers.

  exec_state_t            state_r;
  exec_state_t            state_nxt;
  logic    [`PC_W-1:0]    pc_r;
  logic    [`PC_W-1:0]    pc_nxt;
  logic    [`SP_W-1:0]    sp_r;
  logic    [`SP_W-1:0]    sp_nxt;
  logic    [`PC_W-1:0]    stack_r [`STACK_DEPTH];
  logic    [`PC_W-1:0]    push_val;
  logic                   push;
  core_regs_t             regs_r;
  core_regs_t             regs_nxt;
  logic                   taken_nxt;
  logic    [`SP_W-1:0]    top_idx;
  logic                   busy_r;
  logic                   busy_nxt;
  logic    [`PC_W-1:0]    top_r;
  logic    [`PC_W-1:0]    top_nxt;
  logic    [`SP_W-1:0]    below_idx;

  assign top_idx = sp_r - 3'h1;

  always_comb
  begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    sp_nxt    = sp_r;
    regs_nxt  = regs_r;
    push      = 1'b0;
    push_val  = pc_r + 13'h0001;
    taken_nxt = 1'b0;
    unique case (state_r)
      ST_FETCH:
      begin
        if (instr.valid)
        begin
          taken_nxt = 1'b1;
          pc_nxt    = pc_r + 13'h0001;
          unique case (op)
            OP_RETURN:
            begin
              // The second cycle is spent flushing the prefetched word.
              pc_nxt    = stack_r[top_idx];
              sp_nxt    = top_idx;
              state_nxt = ST_FLUSH;
            end
            OP_RET_INT:
            begin
              pc_nxt    = stack_r[top_idx];
              sp_nxt    = top_idx;
              state_nxt = ST_FLUSH;
              regs_nxt.intctl[`INT_EN_BIT] = 1'b1;
            end
            OP_RET_LIT:
            begin
              regs_nxt.w = literal;
              pc_nxt    = stack_r[top_idx];
              sp_nxt    = top_idx;
              state_nxt = ST_FLUSH;
            end
            OP_CALL:
            begin
              push      = 1'b1;
              sp_nxt    = sp_r + 3'h1;
              // Upper bits of the target read as zero; no page latch here.
              pc_nxt    = {2'b00, instr.word[10:0]};
              state_nxt = ST_FLUSH;
            end
            default:
            begin
              pc_nxt = pc_r + 13'h0001;
            end
          endcase
        end
      end
      ST_FLUSH:
      begin
        state_nxt = ST_FETCH;
      end
    endcase
    busy_nxt = (state_nxt == ST_FLUSH);
  end

  // Sequencer: the flush state and the busy flag that advertises it.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_FETCH;
      busy_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      busy_r  <= busy_nxt;
    end
  end

  // Program counter and stack pointer.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_r <= `PC_RST;
      sp_r <= '0;
    end
    else
    begin
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
    end
  end

  // Working, status and interrupt control registers.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      regs_r <= '{status: `STATUS_RST, w: `W_RST, intctl: `INTCTL_RST};
    else
      regs_r <= regs_nxt;
  end

  // Acceptance strobe, high for the one cycle after a word is taken.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      instr_taken <= 1'b0;
    else
      instr_taken <= taken_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Return stack storage.

  // The stack is a circular array; overflow wraps as in the core.
  // Its contents are not reset, so a pop before any push reads garbage.
  always_ff @(posedge ref_clk)
  begin
    if (push)
      stack_r[sp_r] <= push_val;
  end

  ////////////////////////////////////////////////////////////////////////
  // Copy of the stack top.

  // A registered copy keeps the top entry output on a flop of its own.
  assign below_idx = sp_nxt - 3'h1;

  always_comb
  begin
    top_nxt = top_r;
    if (push)
      top_nxt = push_val;
    else if (sp_nxt != sp_r)
      top_nxt = stack_r[below_idx];
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      top_r <= `PC_RST;
    else
      top_r <= top_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, each taken straight from a flop.

  assign pc                      = pc_r;
  assign regs                    = regs_r;
  assign global_interrupt_enable = regs_r.intctl[`INT_EN_BIT];
  assign stack_top_entry         = top_r;
  assign busy                    = busy_r;

endmodule

//--- dv/ret_exec_checker.sv
// Assertions for the return instruction execution block.
`timescale 1ns/1ns
`include "ret_exec_defs.svh"
module ret_exec_checker
  import ret_exec_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             rstn,
  input wire instr_t           instr,
  input wire logic             instr_taken,
  input wire logic [`PC_W-1:0] pc,
  input wire core_regs_t       regs,
  input wire logic             global_interrupt_enable,
  input wire logic [`PC_W-1:0] stack_top_entry,
  input wire logic             busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_take(logic [13:0] op);
    instr.valid && !busy && instr.word == op;
  endsequence
  sequence s_lw;
    instr.valid && !busy && instr.word[13:8] == `OPC_RET_LIT_HI;
  endsequence
  // A pop lands the old top in pc and holds busy for one extra cycle.
  sequence s_pop;
    pc == $past(stack_top_entry) && busy ##1 !busy;
  endsequence
  a_int_ret_pc: assert property (s_take(`OPC_RET_INT) |=> s_pop)
    else $error("interrupt return pc wrong");
  a_int_ret_enable: assert property (s_take(`OPC_RET_INT) |=>
    global_interrupt_enable && $stable(regs.status))
    else $error("interrupt enable not set");
  a_lit_ret_w: assert property (s_lw |=>
    regs.w == $past(instr.word[7:0]) && $stable(regs.status))
    else $error("literal not in w");
  a_lit_ret_pc: assert property (s_lw |=> s_pop)
    else $error("literal return pc wrong");
  a_take_strobe: assert property (instr.valid && !busy |=>
    instr_taken) else $error("word not taken");
  a_busy_refuses: assert property (busy |=> !instr_taken)
    else $error("word taken while busy");
  a_return_only_pc: assert property (s_take(`OPC_RETURN) |=>
    ($stable(regs) && $stable(global_interrupt_enable)) ##0 s_pop)
    else $error("plain return wrong");
endmodule
bind return_instruction_execution ret_exec_checker i_chk(.ref_clk, .rstn,
  .instr, .instr_taken, .pc, .regs, .global_interrupt_enable,
  .stack_top_entry, .busy);

//--- dv/tb_top.sv
// Testbench for the return instruction execution block.
`timescale 1ns/1ns
`include "ret_exec_defs.svh"
module tb_top import ret_exec_pkg::*;;
  logic             ref_clk = 1'b0;
  logic             rstn = 1'b0;
  instr_t           instr = '0;
  logic             instr_taken, global_interrupt_enable, busy;
  logic [`PC_W-1:0] pc, stack_top_entry;
  core_regs_t       regs;
  logic [`PC_W-1:0] cur = '0;
  logic [`PC_W-1:0] ret_pc = '0;
  int               err_total = 0;
  int               n_checks = 0;
  int               cyc = 0;
  always #5 ref_clk = ~ref_clk;
  return_instruction_execution i_return_instruction_execution(.ref_clk,
    .rstn, .instr, .instr_taken, .pc, .regs, .global_interrupt_enable,
    .stack_top_entry, .busy);
  task automatic chk(string n, logic [12:0] s, logic [12:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic op(logic [13:0] wd);
    @(negedge ref_clk);
    chk("busy", busy, 1'b0);
    instr <= '{1'b1, wd};
    @(negedge ref_clk);
    instr.valid <= 1'b0;
    chk("taken", instr_taken, 1'b1);
  endtask
  // The return address is the word after the call.
  task automatic do_call(logic [10:0] t);
    ret_pc = cur + 13'h1;
    cur = ret_pc;
    op({3'b100, t});
  endtask
  task automatic t_lit_ret(logic [7:0] k);
    do_call(11'h2a5);
    chk("top", stack_top_entry, ret_pc);
    op({`OPC_RET_LIT_HI, k});
    chk("pc", pc, ret_pc);
    chk("busy", busy, 1'b1);
    chk("w", regs.w, k);
    chk("status", regs.status, 8'h00);
  endtask
  task automatic t_int_ret;
    do_call(11'h0f0);
    chk("top", stack_top_entry, ret_pc);
    op(`OPC_RET_INT);
    chk("pc", pc, ret_pc);
    chk("int_en", global_interrupt_enable, 1'b1);
    chk("status", regs.status, 8'h00);
  endtask
  // A one-cycle word first moves the address that the call then pushes.
  task automatic t_return(logic g);
    op(`OPC_NOP);
    cur = cur + 13'h1;
    chk("pc", pc, cur);
    do_call(11'h7ff);
    op(`OPC_RETURN);
    chk("pc", pc, ret_pc);
    chk("w", regs.w, 8'hff);
    chk("int_en", global_interrupt_enable, g);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 400)
    begin
      err_total++;
      complete_run();
    end
  end
  initial
  begin
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    t_lit_ret(8'h00);
    t_lit_ret(8'hff);
    t_return(1'b0);
    t_int_ret();
    t_return(1'b1);
    complete_run();
  end
endmodule
